/* File: hdl/mbs_params.svh */
// Purpose: Constants of the serial slave request handler
// Assumes: Included by the mbs_crc16 and mbs_function_handler design files
// Notes:   Offsets and codes only, no logic
`ifndef MBS_PARAMS_SVH
`define MBS_PARAMS_SVH

`define MBS_FC_RD_COILS   8'h01
`define MBS_FC_RD_REGS    8'h03
`define MBS_FC_WR_COIL    8'h05
`define MBS_FC_WR_REG     8'h06
`define MBS_FC_ERR_FLAG   8'h80
`define MBS_EXC_ADDR      8'h02
`define MBS_EXC_VALUE     8'h03
`define MBS_EXC_NONE      8'h00
`define MBS_BCAST_ADDR    8'h00
`define MBS_MAX_SLAVE     8'hF7
`define MBS_QUERY_LEN     8'h08
`define MBS_RXCNT_MAX     8'hFF
`define MBS_MAX_ITEMS     16'h0008
`define MBS_STAT_LAST     16'h0007
`define MBS_CMD_FIRST     16'h0064
`define MBS_CMD_LAST      16'h006B
`define MBS_COIL_ON       16'hFF00
`define MBS_COIL_OFF      16'h0000
`define MBS_BASIC_BASE    16'h1388
`define MBS_VAR_CMD       16'h138B
`define MBS_VAR_SPEED     16'h138C
`define MBS_SPEED_RST     16'h0000
`define MBS_CMD_RST       8'h00
`define MBS_CRC_INIT      16'hFFFF
`define MBS_CRC_POLY      16'hA001
`define MBS_TX_DEPTH      32

`endif

/* File: hdl/mbs_pkg.sv */
// Purpose: Types of the serial slave request handler
// Assumes: Nothing
// Notes:   States carry no explicit codes
`default_nettype none
package mbs_pkg;

    // Eighteen states need five bits
    typedef enum logic [4:0] {
        ST_RX,
        ST_CHECK,
        ST_EXEC,
        ST_HDR_A,
        ST_HDR_F,
        ST_BCNT,
        ST_BITS,
        ST_REG_RD,
        ST_REG_HI,
        ST_REG_LO,
        ST_ECHO,
        ST_EXC,
        ST_SEND_LD,
        ST_SEND_FETCH,
        ST_SEND_GO,
        ST_CRC_PREP,
        ST_CRC_LO,
        ST_CRC_HI
    } mbs_state_type;

endpackage
`default_nettype wire

/* File: hdl/mbs_crc16.sv */
// Purpose: Running frame check over a byte stream
// Assumes: One byte per enable; clear wins over enable
// Notes:   Over a whole good frame including its check bytes the value ends at zero
`timescale 1ns/1ps
`default_nettype none
`include "mbs_params.svh"
module mbs_crc16
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        clr,
    input  wire logic        en,
    input  wire logic [7:0]  data,
    output var  logic [15:0] crc_q
);

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] t;
        t = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++)
        begin
            t = t[0] ? ((t >> 1) ^ `MBS_CRC_POLY) : (t >> 1);
        end
        return t;
    endfunction

    always_ff @(posedge clk)
    begin
        if (rst || clr)
            crc_q <= `MBS_CRC_INIT;
        else if (en)
            crc_q <= crc_byte(crc_q, data);
    end

    a_crc_clear_init : assert property (@(posedge clk) disable iff (rst)
        clr |=> crc_q == `MBS_CRC_INIT) else $error("crc not preset after clear");

endmodule // mbs_crc16
`default_nettype wire

/* File: hdl/mbs_frame_ram.sv */
// Purpose: Response byte store
// Assumes: One write and one read port
// Notes:   Read data come out of a register, one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module mbs_frame_ram #(
    parameter int DW    = 8,
    parameter int DEPTH = 32,
    parameter int AW    = $clog2(DEPTH)
)
(
    input  wire logic          clk,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output var  logic [DW-1:0] rd_data
);

    logic [DW-1:0] mem [0:DEPTH-1];

    always_ff @(posedge clk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
    end

    always_ff @(posedge clk)
    begin
        rd_data <= mem[rd_addr];
    end

endmodule // mbs_frame_ram
`default_nettype wire

/* File: hdl/mbs_function_handler.sv */
// Purpose: Slave request handler for coil/register read and single writes
// Assumes: Bytes arrive checked for framing; RX_END marks the frame gap
// Notes:   Response is built in a small store, then streamed with its check
`timescale 1ns/1ps
`default_nettype none
`include "mbs_params.svh"
module mbs_function_handler #(
    parameter int TX_DEPTH = `MBS_TX_DEPTH,
    parameter int AW       = $clog2(TX_DEPTH)
)
(
    input  wire logic        CLOCK,
    input  wire logic        SYS_RST,
    input  wire logic [7:0]  SLAVE_ADDR,
    input  wire logic        RX_VALID,
    input  wire logic [7:0]  RX_DATA,
    input  wire logic        RX_END,
    output logic             TX_VALID,
    output logic [7:0]       TX_DATA,
    output logic             TX_LAST,
    input  wire logic        TX_READY,
    input  wire logic [7:0]  STATUS_BITS,
    output logic [7:0]       CMD_BITS,
    output logic [15:0]      SPEED_REF,
    output logic [15:0]      REG_ADDR,
    output logic             REG_RD,
    input  wire logic [15:0] REG_RDATA,
    output logic             REG_WR,
    output logic [15:0]      REG_WDATA
);

    mbs_pkg::mbs_state_type state_r;
    logic [7:0]    rx_b_r [0:7];
    logic [7:0]    rx_cnt_r;
    logic [7:0]    cmd_r;
    logic [15:0]   speed_r;
    logic          err_r;
    logic [7:0]    exc_code_r;
    logic [AW-1:0] tx_len_r;
    logic [AW-1:0] snd_r;
    logic [2:0]    idx_r;
    logic [15:0]   item_r;
    logic [15:0]   addr_cur_r;
    logic [7:0]    acc_r;
    logic [7:0]    lo_r;
    logic [7:0]    tx_data_r;
    logic [15:0]   crc_q;
    logic [7:0]    ram_q;
    logic [7:0]    fc;
    logic [15:0]   start;
    logic [15:0]   qty;
    logic [15:0]   last;
    logic          bcast;
    logic          own;
    logic          crc_clr;
    logic          crc_en;
    logic [7:0]    crc_data;
    logic          emit;
    logic [7:0]    emit_data;
    logic          bit_val;
    logic [7:0]    acc_nxt;
    logic [15:0]   reg_word;
    logic [7:0]    exec_code;
    logic          exec_drop;
    logic [2:0]    coil_idx;

    function automatic logic in_bits(input logic [15:0] a);
        return (a <= `MBS_STAT_LAST) || (a >= `MBS_CMD_FIRST && a <= `MBS_CMD_LAST);
    endfunction

    function automatic logic [7:0] bits_to_bytes(input logic [15:0] q);
        logic [15:0] t;
        t = q + 16'h0007;
        return t[10:3];
    endfunction

    assign fc    = rx_b_r[1];
    assign start = {rx_b_r[2], rx_b_r[3]};
    assign qty   = {rx_b_r[4], rx_b_r[5]};
    assign last  = start + qty - 16'h0001;
    assign bcast = (rx_b_r[0] == `MBS_BCAST_ADDR);
    assign own   = (rx_b_r[0] == SLAVE_ADDR) && (SLAVE_ADDR != `MBS_BCAST_ADDR) && (SLAVE_ADDR <= `MBS_MAX_SLAVE);
    assign coil_idx = 3'(start - `MBS_CMD_FIRST);

    assign CMD_BITS  = cmd_r;
    assign SPEED_REF = speed_r;
    assign TX_DATA   = tx_data_r;
    assign REG_ADDR  = addr_cur_r;
    assign REG_WDATA = qty;
    assign TX_VALID  = (state_r == mbs_pkg::ST_SEND_GO) || (state_r == mbs_pkg::ST_CRC_LO) ||
                       (state_r == mbs_pkg::ST_CRC_HI);
    assign TX_LAST   = (state_r == mbs_pkg::ST_CRC_HI);
    assign REG_RD    = (state_r == mbs_pkg::ST_REG_RD);
    // External store gets writes outside the internal variables
    assign REG_WR    = (state_r == mbs_pkg::ST_EXEC) && (fc == `MBS_FC_WR_REG) &&
                       (start != `MBS_VAR_SPEED) && (start != `MBS_VAR_CMD);

    // Check runs over received bytes, then over sent bytes
    assign crc_clr  = (state_r == mbs_pkg::ST_CHECK) || ((state_r == mbs_pkg::ST_CRC_HI) && TX_READY);
    assign crc_en   = ((state_r == mbs_pkg::ST_RX) && RX_VALID) || ((state_r == mbs_pkg::ST_SEND_GO) && TX_READY);
    assign crc_data = (state_r == mbs_pkg::ST_RX) ? RX_DATA : tx_data_r;

    mbs_crc16 u_crc (
        .clk   (CLOCK),
        .rst   (SYS_RST),
        .clr   (crc_clr),
        .en    (crc_en),
        .data  (crc_data),
        .crc_q (crc_q)
    );

    mbs_frame_ram #(.DW(8), .DEPTH(TX_DEPTH), .AW(AW)) u_ram (
        .clk     (CLOCK),
        .wr_en   (emit),
        .wr_addr (tx_len_r),
        .wr_data (emit_data),
        .rd_addr (snd_r),
        .rd_data (ram_q)
    );

    // Status bits and command bits share one bit space
    assign bit_val = (addr_cur_r <= `MBS_STAT_LAST) ? STATUS_BITS[addr_cur_r[2:0]]
                                                   : cmd_r[3'(addr_cur_r - `MBS_CMD_FIRST)];
    // Bit n of the run goes to position n mod 8
    assign acc_nxt = acc_r | (8'(bit_val) << item_r[2:0]);
    // Internal basic variables answer before the external store
    assign reg_word = (addr_cur_r == `MBS_VAR_SPEED) ? speed_r :
                      (addr_cur_r == `MBS_VAR_CMD) ? {8'h00, cmd_r} : REG_RDATA;

    always_comb
    begin
        exec_code = `MBS_EXC_NONE;
        exec_drop = bcast;
        case (fc)
            // Contiguous bit run inside one bank
            `MBS_FC_RD_COILS:
            begin
                if (qty == 16'h0000 || qty > `MBS_MAX_ITEMS)
                    exec_code = `MBS_EXC_VALUE;
                else if (!in_bits(start) || !in_bits(last) || ((start <= `MBS_STAT_LAST) != (last <= `MBS_STAT_LAST)))
                    exec_code = `MBS_EXC_ADDR;
            end
            `MBS_FC_RD_REGS:
            begin
                if (qty == 16'h0000 || qty > `MBS_MAX_ITEMS)
                    exec_code = `MBS_EXC_VALUE;
            end
            // Only command bits accept a write
            `MBS_FC_WR_COIL:
            begin
                // Broadcast write runs but stays silent
                exec_drop = bcast;
                if (start < `MBS_CMD_FIRST || start > `MBS_CMD_LAST)
                    exec_code = `MBS_EXC_ADDR;
                else if (qty != `MBS_COIL_ON && qty != `MBS_COIL_OFF)
                    exec_code = `MBS_EXC_VALUE;
            end
            `MBS_FC_WR_REG:
            begin
                exec_drop = bcast;
            end
            default:
            begin
                exec_drop = 1'b1;
            end
        endcase
    end

    always_comb
    begin
        emit      = 1'b0;
        emit_data = 8'h00;
        case (state_r)
            mbs_pkg::ST_HDR_A:
            begin
                emit      = 1'b1;
                emit_data = rx_b_r[0];
            end
            mbs_pkg::ST_HDR_F:
            begin
                emit      = 1'b1;
                emit_data = err_r ? (fc | `MBS_FC_ERR_FLAG) : fc;
            end
            mbs_pkg::ST_BCNT:
            begin
                emit      = 1'b1;
                emit_data = (fc == `MBS_FC_RD_COILS) ? bits_to_bytes(qty) : {qty[6:0], 1'b0};
            end
            // Byte closes at bit 7 or at the last bit, upper zero
            mbs_pkg::ST_BITS:
            begin
                emit      = (item_r[2:0] == 3'h7) || (item_r == qty - 16'h0001);
                emit_data = acc_nxt;
            end
            mbs_pkg::ST_REG_HI:
            begin
                emit      = 1'b1;
                emit_data = reg_word[15:8];
            end
            mbs_pkg::ST_REG_LO:
            begin
                emit      = 1'b1;
                emit_data = lo_r;
            end
            // Echo of address and value fields
            mbs_pkg::ST_ECHO:
            begin
                emit      = 1'b1;
                emit_data = rx_b_r[idx_r];
            end
            mbs_pkg::ST_EXC:
            begin
                emit      = 1'b1;
                emit_data = exc_code_r;
            end
            default:
            begin
                emit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            state_r <= mbs_pkg::ST_RX;
        else
            case (state_r)
                mbs_pkg::ST_RX:
                    if (RX_END)
                        state_r <= mbs_pkg::ST_CHECK;
                // Bad check or wrong length dropped; foreign address dropped
                mbs_pkg::ST_CHECK:
                    state_r <= (crc_q == 16'h0000 && rx_cnt_r == `MBS_QUERY_LEN && (own || bcast))
                               ? mbs_pkg::ST_EXEC : mbs_pkg::ST_RX;
                mbs_pkg::ST_EXEC:
                    state_r <= exec_drop ? mbs_pkg::ST_RX : mbs_pkg::ST_HDR_A;
                mbs_pkg::ST_HDR_A:
                    state_r <= mbs_pkg::ST_HDR_F;
                mbs_pkg::ST_HDR_F:
                    if (err_r)
                        state_r <= mbs_pkg::ST_EXC;
                    else if (fc == `MBS_FC_RD_COILS || fc == `MBS_FC_RD_REGS)
                        state_r <= mbs_pkg::ST_BCNT;
                    else
                        state_r <= mbs_pkg::ST_ECHO;
                mbs_pkg::ST_BCNT:
                    state_r <= (fc == `MBS_FC_RD_COILS) ? mbs_pkg::ST_BITS : mbs_pkg::ST_REG_RD;
                mbs_pkg::ST_BITS:
                    if (item_r == qty - 16'h0001)
                        state_r <= mbs_pkg::ST_SEND_LD;
                mbs_pkg::ST_REG_RD:
                    state_r <= mbs_pkg::ST_REG_HI;
                mbs_pkg::ST_REG_HI:
                    state_r <= mbs_pkg::ST_REG_LO;
                mbs_pkg::ST_REG_LO:
                    state_r <= (item_r == qty - 16'h0001) ? mbs_pkg::ST_SEND_LD : mbs_pkg::ST_REG_RD;
                // Fields 2 to 5 copied back
                mbs_pkg::ST_ECHO:
                    if (idx_r == 3'h5)
                        state_r <= mbs_pkg::ST_SEND_LD;
                mbs_pkg::ST_EXC:
                    state_r <= mbs_pkg::ST_SEND_LD;
                mbs_pkg::ST_SEND_LD:
                    state_r <= mbs_pkg::ST_SEND_FETCH;
                mbs_pkg::ST_SEND_FETCH:
                    state_r <= mbs_pkg::ST_SEND_GO;
                mbs_pkg::ST_SEND_GO:
                    if (TX_READY)
                        state_r <= (snd_r == tx_len_r - 1'b1) ? mbs_pkg::ST_CRC_PREP : mbs_pkg::ST_SEND_LD;
                mbs_pkg::ST_CRC_PREP:
                    state_r <= mbs_pkg::ST_CRC_LO;
                mbs_pkg::ST_CRC_LO:
                    if (TX_READY)
                        state_r <= mbs_pkg::ST_CRC_HI;
                mbs_pkg::ST_CRC_HI:
                    if (TX_READY)
                        state_r <= mbs_pkg::ST_RX;
                default:
                    state_r <= mbs_pkg::ST_RX;
            endcase
    end

    // Bytes beyond eight only count, so long frames fail the length test
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST || state_r == mbs_pkg::ST_CHECK)
            rx_cnt_r <= 8'h00;
        else if (state_r == mbs_pkg::ST_RX && RX_VALID)
        begin
            if (rx_cnt_r < `MBS_QUERY_LEN)
                rx_b_r[rx_cnt_r[2:0]] <= RX_DATA;
            if (rx_cnt_r != `MBS_RXCNT_MAX)
                rx_cnt_r <= rx_cnt_r + 8'h01;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            err_r      <= 1'b0;
            exc_code_r <= `MBS_EXC_NONE;
        end
        else if (state_r == mbs_pkg::ST_EXEC)
        begin
            err_r      <= (exec_code != `MBS_EXC_NONE);
            exc_code_r <= exec_code;
        end
    end

    // Coil values; command variable writes reach the bits
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            cmd_r <= `MBS_CMD_RST;
        else if (state_r == mbs_pkg::ST_EXEC && exec_code == `MBS_EXC_NONE)
        begin
            if (fc == `MBS_FC_WR_COIL)
                cmd_r[coil_idx] <= (qty == `MBS_COIL_ON);
            else if (fc == `MBS_FC_WR_REG && start == `MBS_VAR_CMD)
                cmd_r <= qty[7:0];
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            speed_r <= `MBS_SPEED_RST;
        else if (state_r == mbs_pkg::ST_EXEC && fc == `MBS_FC_WR_REG && start == `MBS_VAR_SPEED)
            speed_r <= qty;
    end

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST || state_r == mbs_pkg::ST_CHECK)
        begin
            tx_len_r   <= '0;
            snd_r      <= '0;
            idx_r      <= 3'h2;
            item_r     <= 16'h0000;
            acc_r      <= 8'h00;
            lo_r       <= 8'h00;
            addr_cur_r <= start;
        end
        else
        begin
            if (emit)
                tx_len_r <= tx_len_r + 1'b1;
            if (state_r == mbs_pkg::ST_BITS || state_r == mbs_pkg::ST_REG_LO)
            begin
                item_r     <= item_r + 16'h0001;
                addr_cur_r <= addr_cur_r + 16'h0001;
            end
            if (state_r == mbs_pkg::ST_BITS)
                acc_r <= emit ? 8'h00 : acc_nxt;
            if (state_r == mbs_pkg::ST_REG_HI)
                lo_r <= reg_word[7:0];
            if (state_r == mbs_pkg::ST_ECHO)
                idx_r <= idx_r + 3'h1;
            if (state_r == mbs_pkg::ST_SEND_GO && TX_READY)
                snd_r <= snd_r + 1'b1;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            tx_data_r <= 8'h00;
        else if (state_r == mbs_pkg::ST_SEND_FETCH)
            tx_data_r <= ram_q;
        else if (state_r == mbs_pkg::ST_CRC_PREP)
            tx_data_r <= crc_q[7:0];
        else if (state_r == mbs_pkg::ST_CRC_LO && TX_READY)
            tx_data_r <= crc_q[15:8];
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    a_bit_count_field : assert property ((state_r == mbs_pkg::ST_BCNT && fc == `MBS_FC_RD_COILS)
        |-> emit_data == bits_to_bytes(qty)) else $error("bad bit byte count");
    a_bits_zero_fill : assert property ((state_r == mbs_pkg::ST_BITS && emit)
        |-> ((emit_data >> item_r[2:0]) >> 1) == 8'h00) else $error("upper bits not zero");
    a_reg_byte_count : assert property ((state_r == mbs_pkg::ST_BCNT && fc == `MBS_FC_RD_REGS)
        |-> emit_data == {qty[6:0], 1'b0}) else $error("bad register byte count");
    a_coil_write_on : assert property ((state_r == mbs_pkg::ST_EXEC && fc == `MBS_FC_WR_COIL &&
        exec_code == `MBS_EXC_NONE && qty == `MBS_COIL_ON) |=> cmd_r[$past(coil_idx)])
        else $error("coil not set");
    a_echo_length : assert property ((state_r == mbs_pkg::ST_ECHO && idx_r == 3'h5)
        |=> tx_len_r == AW'(6) && state_r == mbs_pkg::ST_SEND_LD) else $error("echo length wrong");
    a_speed_store : assert property ((state_r == mbs_pkg::ST_EXEC && fc == `MBS_FC_WR_REG &&
        start == `MBS_VAR_SPEED) |=> SPEED_REF == $past(qty)) else $error("speed not stored");
    a_status_read_only : assert property ((state_r == mbs_pkg::ST_EXEC && fc == `MBS_FC_WR_COIL &&
        start <= `MBS_STAT_LAST && !bcast) |=> err_r && state_r == mbs_pkg::ST_HDR_A ##1 emit_data[7])
        else $error("status write not refused");
    a_count_limit : assert property ((state_r == mbs_pkg::ST_EXEC && fc == `MBS_FC_RD_REGS &&
        qty > `MBS_MAX_ITEMS && !bcast) |=> err_r && exc_code_r == `MBS_EXC_VALUE)
        else $error("oversized read not refused");
    a_bcast_quiet : assert property ((state_r == mbs_pkg::ST_EXEC && bcast)
        |=> state_r == mbs_pkg::ST_RX && !TX_VALID) else $error("broadcast answered");
    a_crc_drop : assert property ((state_r == mbs_pkg::ST_CHECK && crc_q != 16'h0000)
        |=> state_r == mbs_pkg::ST_RX) else $error("bad frame accepted");
    a_foreign_drop : assert property ((state_r == mbs_pkg::ST_CHECK && !own && !bcast)
        |=> state_r == mbs_pkg::ST_RX) else $error("foreign frame accepted");

    c_read_bits : cover property (state_r == mbs_pkg::ST_BITS ##1 state_r == mbs_pkg::ST_SEND_LD);
    c_read_regs : cover property (state_r == mbs_pkg::ST_REG_LO ##1 state_r == mbs_pkg::ST_SEND_LD);
    c_echo_done : cover property (state_r == mbs_pkg::ST_ECHO ##1 state_r == mbs_pkg::ST_SEND_LD);
    c_error_sent : cover property (state_r == mbs_pkg::ST_EXC);

endmodule // mbs_function_handler
`default_nettype wire

/* File: testbench/mbs_master_model.sv */
// Purpose: Master side of the link
// Assumes: Frames handed over whole
// Notes:   Sink stalls every other cycle
`timescale 1ns/1ps
`default_nettype none
module mbs_master_model
(
    input  wire logic       clk,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_end,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last,
    output logic            tx_ready
);
    logic [7:0] got[$];
    int         last_pos;
    initial
    begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        rx_end   = 1'b0;
        tx_ready = 1'b0;
    end
    task automatic send(input logic [7:0] b[$]);
        foreach (b[i])
        begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_data  <= b[i];
        end
        // Released line shows the inverse, never a stale byte
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_data  <= ~rx_data;
        rx_end   <= 1'b1;
        @(posedge clk);
        rx_end <= 1'b0;
    endtask
    always @(posedge clk)
    begin
        tx_ready <= ~tx_ready;
        if (tx_valid && tx_ready)
        begin
            got.push_back(tx_data);
            if (tx_last)
                last_pos = got.size();
        end
    end
endmodule // mbs_master_model
`default_nettype wire

/* File: testbench/test_mbs_function_handler.sv */
// Purpose: Bench of the request handler
// Assumes: Own address 1, status bits 04
// Notes:   Check bytes computed here
`timescale 1ns/1ps
`default_nettype none
module test_mbs_function_handler;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        rx_valid, rx_end, tx_valid, tx_last, tx_ready, reg_rd, reg_wr;
    logic [7:0]  rx_data, tx_data, cmd;
    logic [15:0] spd, raddr, wdata;
    logic [15:0] rdata = 16'h0000;
    int          failures = 0;
    int          checks = 0;
    always #5 clk = ~clk;
    mbs_function_handler dut_u (.CLOCK(clk), .SYS_RST(rst), .SLAVE_ADDR(8'h01), .RX_VALID(rx_valid),
        .RX_DATA(rx_data), .RX_END(rx_end), .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_LAST(tx_last),
        .TX_READY(tx_ready), .STATUS_BITS(8'h04), .CMD_BITS(cmd), .SPEED_REF(spd), .REG_ADDR(raddr),
        .REG_RD(reg_rd), .REG_RDATA(rdata), .REG_WR(reg_wr), .REG_WDATA(wdata));
    mbs_master_model mm_u (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));
    // External store answers the cycle after the strobe
    always @(posedge clk)
        if (reg_rd)
            rdata <= (raddr == 16'h0002) ? 16'h09C4 : 16'h028A;
    // Last external write seen on the store port
    logic [15:0] wr_a = 16'h0000;
    logic [15:0] wr_d = 16'h0000;
    always @(posedge clk)
        if (reg_wr)
        begin
            wr_a <= raddr;
            wr_d <= wdata;
        end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c = 16'hFFFF;
        foreach (b[i])
        begin
            c ^= {8'h00, b[i]};
            repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        end
        return c;
    endfunction
    // Kind 0 echo, 1 answer, 2 silent, 3 corrupt check and silent
    task automatic xfer(input int kind, input logic [47:0] f, input logic [55:0] r, input int nr);
        logic [7:0]  q[$];
        logic [7:0]  e[$];
        logic [15:0] c;
        for (int i = 5; i >= 0; i--) q.push_back(f[8*i +: 8]);
        for (int i = nr - 1; i >= 0; i--) e.push_back(r[8*i +: 8]);
        c = crc16(q);
        q.push_back(c[7:0]);
        q.push_back(c[15:8] ^ 8'(kind == 3));
        c = crc16(e);
        if (kind == 0)
            e = q;
        if (kind == 1)
        begin
            e.push_back(c[7:0]);
            e.push_back(c[15:8]);
        end
        if (kind > 1)
            e.delete();
        mm_u.got.delete();
        mm_u.last_pos = 0;
        mm_u.send(q);
        for (int n = 0; n < 300 && (kind > 1 || mm_u.last_pos == 0); n++) @(posedge clk);
        check(16'(mm_u.got.size()), 16'(e.size()));
        foreach (e[i]) check(16'(mm_u.got[i]), 16'(e[i]));
        if (kind < 2) check(16'(mm_u.last_pos), 16'(e.size()));
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check(16'(cmd), 16'h0000);
        xfer(0, 48'h0105_006B_FF00, 0, 0);
        check(16'(cmd), 16'h0080);
        xfer(1, 48'h0101_0064_0008, 56'h0101_0180, 4);
        xfer(0, 48'h0105_006B_0000, 0, 0);
        check(16'(cmd), 16'h0000);
        xfer(1, 48'h0101_0001_0002, 56'h0101_0102, 4);
        xfer(0, 48'h0106_138C_0BB8, 0, 0);
        check(spd, 16'h0BB8);
        xfer(1, 48'h0103_138C_0001, 56'h01_0302_0BB8, 5);
        xfer(1, 48'h0103_0002_0002, 56'h01_0304_09C4_028A, 7);
        xfer(0, 48'h0106_0064_000A, 0, 0);
        check(wr_a, 16'h0064);
        check(wr_d, 16'h000A);
        xfer(1, 48'h0105_0003_FF00, 56'h01_8502, 3);
        xfer(1, 48'h0103_0002_0009, 56'h01_8303, 3);
        xfer(3, 48'h0106_138C_1111, 0, 0);
        xfer(2, 48'h0206_138C_1111, 0, 0);
        check(spd, 16'h0BB8);
        xfer(2, 48'h0006_138C_1234, 0, 0);
        check(spd, 16'h1234);
        xfer(0, 48'h0106_138B_0005, 0, 0);
        check(16'(cmd), 16'h0005);
        xfer(1, 48'h0101_0064_0003, 56'h0101_0105, 4);
        finish_test;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        finish_test;
    end
endmodule // test_mbs_function_handler
`default_nettype wire
